// File: gpio_map.svh
// Register map, field positions, reset values and widths of the dual port block
`ifndef GPIO_MAP_SVH
`define GPIO_MAP_SVH

// ============================================================
// Register offsets
`define ADDR_W            8
`define OFF_FIRST_DATA    8'h05
`define OFF_SECOND_DATA   8'h06
`define OFF_INT_CONTROL   8'h0b
`define OFF_OPTION        8'h81
`define OFF_FIRST_DIR     8'h85
`define OFF_SECOND_DIR    8'h86
`define OFF_CONV_CFG      8'h9f

// ============================================================
// Widths and field positions
`define FIRST_W           5
`define SECOND_W          8
`define OPEN_DRAIN_BIT    4
`define PULLUP_N_BIT      7
`define CHANGE_FLAG_BIT   0
`define EXT_INT_BIT       0
`define PROG_CLK_BIT      6
`define PROG_DATA_BIT     7

// ============================================================
// Reset values
`define RST_FIRST_LATCH   5'h00
`define RST_FIRST_DIR     5'h1f
`define RST_SECOND_LATCH  8'h00
`define RST_SECOND_DIR    8'hff
`define RST_OPTION        8'hff
`define RST_CONV_CFG      2'h0

`endif

// File: gpio_pkg.sv
// Types shared by the dual port block
package gpio_pkg;

	// ============================================================
	// Register bus request, one cycle per access
	typedef struct packed {
		logic [7:0] addr;   // Register offset
		logic [7:0] wdata;  // Write data
		logic [7:0] wbits;  // Bits taken from wdata on a port write
		logic       wr;     // Write strobe
		logic       rd;     // Read strobe
	} bus_req_t;

	// ============================================================
	// State of the port block, all but the reset synchroniser
	typedef struct packed {
		logic [4:0] pa_meta;   // First port sync stage one
		logic [4:0] pa_sync;   // First port sync stage two
		logic [7:0] pb_meta;   // Second port sync stage one
		logic [7:0] pb_sync;   // Second port sync stage two
		logic       pm_meta;   // Programming mode stage one
		logic       pm_sync;   // Programming mode stage two
		logic [4:0] pa_latch;  // First port output latch
		logic [4:0] pa_dir;    // First port direction
		logic [7:0] pb_latch;  // Second port output latch
		logic [7:0] pb_dir;    // Second port direction
		logic [7:0] option;    // Option control
		logic [1:0] conv_cfg;  // Converter pin config
		logic [3:0] snap;      // Change-watch snapshot
		logic       chg_flag;  // Port change flag
		logic [7:0] rdata;     // Registered read data
	} state_t;

endpackage : gpio_pkg

// File: gpio_dual_port.sv
// Dual general-purpose port block with change detection and pin sharing
`include "gpio_map.svh"

module gpio_dual_port (
	input  wire logic             I_REF_CLK,      // Core clock, 250 MHz
	input  wire logic             I_RSTN,         // Power-on reset, active low, async
	input  wire logic             I_OTHER_RST,    // Other reset, one-cycle pulse
	input  wire gpio_pkg::bus_req_t I_BUS,        // Register bus request
	output logic [7:0]            O_RDATA,        // Read data, cycle after strobe
	input  wire logic [4:0]       I_PA_PIN,       // First port pin levels
	output logic [4:0]            O_PA_OUT,       // First port drive value
	output logic [4:0]            O_PA_OE,        // First port drive enable
	output logic [3:0]            O_PA_ANALOG,    // First port pin in analog use
	output logic                  O_TIMER_CLK,    // Timer external clock in
	input  wire logic [7:0]       I_PB_PIN,       // Second port pin levels
	output logic [7:0]            O_PB_OUT,       // Second port drive value
	output logic [7:0]            O_PB_OE,        // Second port drive enable
	output logic [7:0]            O_PB_PULLUP,    // Weak pull-up enable per pin
	input  wire logic             I_EXT_INT_EN,   // External interrupt in use
	output logic                  O_EXT_INT,      // External interrupt input
	output logic                  O_PB0_SCHMITT,  // Bit zero Schmitt buffer select
	input  wire logic             I_PROG_MODE,    // Serial programming mode pin
	output logic                  O_PROG_CLK,     // Programming clock input
	output logic                  O_PROG_DATA,    // Programming data input
	output logic                  O_CHANGE_FLAG,  // Port change flag level
	output logic                  O_WAKE          // Wake request to the core
);

	// ============================================================
	// Reset release
	logic rst_meta_ff;  // Reset sync stage one
	logic rst_sync_ff;  // Reset used by the rest of the block

	// Assert at once, release through two flops to avoid a ragged release
	always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	// ============================================================
	// State and next state
	gpio_pkg::state_t st_ff;    // Registered state
	gpio_pkg::state_t nxt_st;   // Next state

	// ============================================================
	// Decoded views of the state
	logic [3:0] analog_sel;     // Pins handed to the converter
	logic [4:0] pa_view;        // First port as software sees it
	logic [7:0] pb_view;        // Second port as software sees it
	logic [3:0] mismatch;       // Change-watch pins that differ
	logic       pb_access;      // Second port read or write
	logic       wr_first;       // Write to first port data
	logic       wr_second;      // Write to second port data
	logic [7:0] rd_mux;         // Read value before its register

	// Converter pin selection: 00 all four analog, 01 pins 2:0 analog with
	// pin 3 as reference, 10 pins 1:0 analog, 11 all digital
	always_comb begin
		case (st_ff.conv_cfg)
			2'h0:    analog_sel = 4'hf;
			2'h1:    analog_sel = 4'hf;  // Pin 3 serves as reference
			2'h2:    analog_sel = 4'h3;
			2'h3:    analog_sel = 4'h0;
			default: analog_sel = 4'hf;
		endcase
	end

	// Read views come from the second sync stage only
	always_comb begin
		// Analog pins read as zero; the open-drain pin always reads its level
		pa_view = st_ff.pa_sync & {1'b1, ~analog_sel};
		pb_view = st_ff.pb_sync;
	end

	// Bus decode
	always_comb begin
		wr_first  = I_BUS.wr && (I_BUS.addr == `OFF_FIRST_DATA);
		wr_second = I_BUS.wr && (I_BUS.addr == `OFF_SECOND_DATA);
		pb_access = (I_BUS.wr || I_BUS.rd) && (I_BUS.addr == `OFF_SECOND_DATA);
	end

	// Only input pins take part; an output pin is always seen as matching
	always_comb begin
		mismatch = (st_ff.pb_sync[7:4] ^ st_ff.snap) & st_ff.pb_dir[7:4];
	end

	// Read multiplexer; unused bits and unmapped offsets read zero
	always_comb begin
		case (I_BUS.addr)
			`OFF_FIRST_DATA:  rd_mux = {3'h0, pa_view};
			`OFF_SECOND_DATA: rd_mux = pb_view;
			`OFF_INT_CONTROL: rd_mux = {7'h0, st_ff.chg_flag};
			`OFF_OPTION:      rd_mux = st_ff.option;
			`OFF_FIRST_DIR:   rd_mux = {3'h0, st_ff.pa_dir};
			`OFF_SECOND_DIR:  rd_mux = st_ff.pb_dir;
			`OFF_CONV_CFG:    rd_mux = {6'h0, st_ff.conv_cfg};
			default:          rd_mux = 8'h00;
		endcase
	end

	// ============================================================
	// Next-state logic
	always_comb begin
		nxt_st = st_ff;

		// Pins pass two stages before anything reads them
		nxt_st.pa_meta = I_PA_PIN;
		nxt_st.pa_sync = st_ff.pa_meta;
		nxt_st.pb_meta = I_PB_PIN;
		nxt_st.pb_sync = st_ff.pb_meta;
		nxt_st.pm_meta = I_PROG_MODE;
		nxt_st.pm_sync = st_ff.pm_meta;

		// Read data stands for one cycle after the strobe
		nxt_st.rdata = I_BUS.rd ? rd_mux : 8'h00;

		// Port writes merge the sampled pins with the new bits, then latch;
		// the latch changes at the closing edge of the write cycle
		if (wr_first) begin
			nxt_st.pa_latch = (I_BUS.wdata[4:0] & I_BUS.wbits[4:0])
				| (pa_view & ~I_BUS.wbits[4:0]);
		end
		if (wr_second) begin
			nxt_st.pb_latch = (I_BUS.wdata & I_BUS.wbits)
				| (pb_view & ~I_BUS.wbits);
		end

		// Plain control registers
		if (I_BUS.wr) begin
			case (I_BUS.addr)
				`OFF_OPTION:    nxt_st.option   = I_BUS.wdata;
				`OFF_FIRST_DIR: nxt_st.pa_dir   = I_BUS.wdata[4:0];
				`OFF_SECOND_DIR: nxt_st.pb_dir  = I_BUS.wdata;
				`OFF_CONV_CFG:  nxt_st.conv_cfg = I_BUS.wdata[1:0];
				default: ;
			endcase
		end

		// Any access to the second port refreshes the snapshot
		if (pb_access) begin
			nxt_st.snap = st_ff.pb_sync[7:4];
		end

		// Software may write the flag; a live mismatch sets it and beats a
		// clear in the same cycle. A mismatch seen in a cycle that accesses
		// the second port is dropped, as the snapshot takes the new level.
		if (I_BUS.wr && (I_BUS.addr == `OFF_INT_CONTROL)) begin
			nxt_st.chg_flag = I_BUS.wdata[`CHANGE_FLAG_BIT];
		end
		if ((|mismatch) && !pb_access) begin
			nxt_st.chg_flag = 1'b1;
		end

		// Other resets: directions and option to ones, latches unchanged
		if (I_OTHER_RST) begin
			nxt_st.pa_dir   = `RST_FIRST_DIR;
			nxt_st.pb_dir   = `RST_SECOND_DIR;
			nxt_st.option   = `RST_OPTION;
			nxt_st.conv_cfg = `RST_CONV_CFG;
		end
	end

	// ============================================================
	// State register; power-on reset loads constants only
	always_ff @(posedge I_REF_CLK or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			st_ff.pa_meta  <= 5'h00;
			st_ff.pa_sync  <= 5'h00;
			st_ff.pb_meta  <= 8'h00;
			st_ff.pb_sync  <= 8'h00;
			st_ff.pm_meta  <= 1'b0;
			st_ff.pm_sync  <= 1'b0;
			st_ff.pa_latch <= `RST_FIRST_LATCH;
			st_ff.pa_dir   <= `RST_FIRST_DIR;
			st_ff.pb_latch <= `RST_SECOND_LATCH;
			st_ff.pb_dir   <= `RST_SECOND_DIR;
			st_ff.option   <= `RST_OPTION;
			st_ff.conv_cfg <= `RST_CONV_CFG;
			st_ff.snap     <= 4'h0;
			st_ff.chg_flag <= 1'b0;
			st_ff.rdata    <= 8'h00;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ============================================================
	// First port pin drivers
	logic [4:0] pa_drive;   // Driver enabled per pin

	// Direction applies even to analog pins; software keeps them set
	always_comb begin
		pa_drive = ~st_ff.pa_dir;
	end

	// Bit four only ever pulls low: it drives while its direction is output and its latch bit is zero
	always_comb begin
		O_PA_OUT = {1'b0, st_ff.pa_latch[3:0]};
		O_PA_OE  = {pa_drive[4] & ~st_ff.pa_latch[4], pa_drive[3:0]};
	end

	// Analog selection and timer clock
	always_comb begin
		O_PA_ANALOG = analog_sel;
		O_TIMER_CLK = st_ff.pa_sync[`OPEN_DRAIN_BIT];
	end

	// ============================================================
	// Second port pin drivers
	logic [7:0] pb_prog_mask;   // Pins taken by serial programming

	// Programming mode owns bits six and seven, so port drivers release them
	always_comb begin
		pb_prog_mask = st_ff.pm_sync ? 8'hc0 : 8'h00;
	end

	always_comb begin
		O_PB_OUT = st_ff.pb_latch;
		O_PB_OE  = ~st_ff.pb_dir & ~pb_prog_mask;
	end

	// Global pull-up enable gated by direction; a driven pin never pulls up
	always_comb begin
		O_PB_PULLUP = {8{~st_ff.option[`PULLUP_N_BIT]}} & st_ff.pb_dir;
	end

	// ============================================================
	// Shared inputs of the second port
	always_comb begin
		O_EXT_INT     = st_ff.pb_sync[`EXT_INT_BIT];
		O_PB0_SCHMITT = I_EXT_INT_EN;
		O_PROG_CLK    = st_ff.pm_sync & st_ff.pb_sync[`PROG_CLK_BIT];
		O_PROG_DATA   = st_ff.pm_sync & st_ff.pb_sync[`PROG_DATA_BIT];
	end

	// ============================================================
	// Status outputs
	// The flag is a level; the core may sleep and this keeps it awake
	always_comb begin
		O_CHANGE_FLAG = st_ff.chg_flag;
		O_WAKE        = st_ff.chg_flag;
		O_RDATA       = st_ff.rdata;
	end

endmodule : gpio_dual_port

// File: gpio_dual_port_properties.sv
// Port-level checker for the dual port block
module gpio_port_checker (
	input  wire logic               I_REF_CLK,
	input  wire logic               I_RSTN,
	input  wire logic               I_OTHER_RST,
	input  wire gpio_pkg::bus_req_t I_BUS,
	input  wire logic [7:0]         O_RDATA,
	input  wire logic [4:0]         I_PA_PIN,
	input  wire logic [4:0]         O_PA_OUT,
	input  wire logic [4:0]         O_PA_OE,
	input  wire logic [3:0]         O_PA_ANALOG,
	input  wire logic               O_TIMER_CLK,
	input  wire logic [7:0]         I_PB_PIN,
	input  wire logic [7:0]         O_PB_OE,
	input  wire logic [7:0]         O_PB_PULLUP,
	input  wire logic               I_EXT_INT_EN,
	input  wire logic               O_EXT_INT,
	input  wire logic               O_PB0_SCHMITT,
	input  wire logic               O_CHANGE_FLAG,
	input  wire logic               O_WAKE
);
	timeunit 1ns;
	timeprecision 1ps;
	// ============================================================
	// Single clock domain, power-on reset masks everything
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RSTN);

	rdata_idle_a: assert property (!$past(I_BUS.rd) |-> O_RDATA == 8'h00)
		else $error("read data seen outside its slot");
	od_high_a: assert property (O_PA_OUT[4] == 1'b0)
		else $error("open-drain pin driven high");
	pullup_out_a: assert property ((O_PB_PULLUP & O_PB_OE) == 8'h00)
		else $error("pull-up left on a driven pin");
	pa_dir_a: assert property (I_BUS.wr && I_BUS.addr == 8'h85 && !I_OTHER_RST
		|=> O_PA_OE[3:0] == ~$past(I_BUS.wdata[3:0])) else $error("first port enable wrong");
	pb_dir_a: assert property (I_BUS.wr && I_BUS.addr == 8'h86 && !I_OTHER_RST
		|=> O_PB_OE[5:0] == ~$past(I_BUS.wdata[5:0])) else $error("second port enable wrong");
	flag_hold_a: assert property (O_CHANGE_FLAG && !(I_BUS.wr && I_BUS.addr == 8'h0b)
		|=> O_CHANGE_FLAG) else $error("change flag dropped without a clear");
	wake_flag_a: assert property (O_WAKE == O_CHANGE_FLAG)
		else $error("wake differs from change flag");
	other_reset_a: assert property (I_OTHER_RST |=> O_PA_OE == 5'h00 && O_PB_OE == 8'h00
		&& O_PB_PULLUP == 8'h00 && O_PA_ANALOG == 4'hf) else $error("other reset state wrong");
	pin_sync_a: assert property (O_TIMER_CLK == $past(I_PA_PIN[4], 2)
		&& O_EXT_INT == $past(I_PB_PIN[0], 2)) else $error("synchronised pin level wrong");
	schmitt_sel_a: assert property (O_PB0_SCHMITT == I_EXT_INT_EN)
		else $error("Schmitt select wrong");
endmodule : gpio_port_checker

bind gpio_dual_port gpio_port_checker i_gpio_port_checker (.I_REF_CLK, .I_RSTN, .I_OTHER_RST,
	.I_BUS, .O_RDATA, .I_PA_PIN, .O_PA_OUT, .O_PA_OE, .O_PA_ANALOG, .O_TIMER_CLK, .I_PB_PIN,
	.O_PB_OE, .O_PB_PULLUP, .I_EXT_INT_EN, .O_EXT_INT, .O_PB0_SCHMITT, .O_CHANGE_FLAG, .O_WAKE);

// File: gpio_pin_model.sv
// Board-side model of the pins of both ports
module gpio_pin_model (
	input  wire logic       i_clk,
	input  wire logic [4:0] i_pa_out,
	input  wire logic [4:0] i_pa_oe,
	input  wire logic [4:0] i_pa_ext,
	input  wire logic [7:0] i_pb_out,
	input  wire logic [7:0] i_pb_oe,
	input  wire logic [7:0] i_pb_pullup,
	input  wire logic [7:0] i_pb_ext,
	input  wire logic [7:0] i_pb_ext_en,
	output logic [4:0]      o_pa_pin,
	output logic [7:0]      o_pb_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// ============================================================
	// Undriven lines wander so a stale level never reads back
	logic [7:0] float_ff = 8'h00;
	always_ff @(posedge i_clk) begin
		float_ff <= ~o_pb_pin;
	end
	// ============================================================
	// Wire resolution: chip drive, then board drive, then pull-up
	always_comb begin
		o_pa_pin = (i_pa_oe & i_pa_out) | (~i_pa_oe & i_pa_ext);
		for (int b = 0; b < 8; b++) begin
			if (i_pb_oe[b]) begin
				o_pb_pin[b] = i_pb_out[b];
			end else if (i_pb_ext_en[b]) begin
				o_pb_pin[b] = i_pb_ext[b];
			end else if (i_pb_pullup[b]) begin
				o_pb_pin[b] = 1'b1;
			end else begin
				o_pb_pin[b] = float_ff[b];
			end
		end
	end
endmodule : gpio_pin_model

// File: test_gpio_dual_port.sv
// Self-checking bench for the dual port block
module test_gpio_dual_port;
	timeunit 1ns;
	timeprecision 1ps;
	// ============================================================
	// Stimulus and observation
	logic               clk, rstn, other_rst, ext_int_en, prog_mode;
	gpio_pkg::bus_req_t bus;
	logic [7:0]         rdata, pb_out, pb_oe, pb_pu, pb_pin, pb_ext, pb_ext_en;
	logic [4:0]         pa_out, pa_oe, pa_pin, pa_ext;
	logic [3:0]         pa_an;
	logic               tmr, eint, schm, pclk, pdat, flag, wake;
	int                 fails, checked;
	logic [7:0]         rst_addr [6] = '{8'h81, 8'h85, 8'h86, 8'h9f, 8'h0b, 8'h10};
	logic [7:0]         rst_val [6] = '{8'hff, 8'h1f, 8'hff, 8'h00, 8'h00, 8'h00};
	logic [7:0]         an_exp [4] = '{8'h10, 8'h10, 8'h1c, 8'h1f};

	gpio_dual_port i_gpio_dual_port (.I_REF_CLK(clk), .I_RSTN(rstn), .I_OTHER_RST(other_rst),
		.I_BUS(bus), .O_RDATA(rdata), .I_PA_PIN(pa_pin), .O_PA_OUT(pa_out), .O_PA_OE(pa_oe),
		.O_PA_ANALOG(pa_an), .O_TIMER_CLK(tmr), .I_PB_PIN(pb_pin), .O_PB_OUT(pb_out),
		.O_PB_OE(pb_oe), .O_PB_PULLUP(pb_pu), .I_EXT_INT_EN(ext_int_en), .O_EXT_INT(eint),
		.O_PB0_SCHMITT(schm), .I_PROG_MODE(prog_mode), .O_PROG_CLK(pclk),
		.O_PROG_DATA(pdat), .O_CHANGE_FLAG(flag), .O_WAKE(wake));
	gpio_pin_model i_gpio_pin_model (.i_clk(clk), .i_pa_out(pa_out), .i_pa_oe(pa_oe),
		.i_pa_ext(pa_ext), .i_pb_out(pb_out), .i_pb_oe(pb_oe), .i_pb_pullup(pb_pu),
		.i_pb_ext(pb_ext), .i_pb_ext_en(pb_ext_en), .o_pa_pin(pa_pin), .o_pb_pin(pb_pin));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// ============================================================
	// Bus, compare and closing tasks
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wbits: m, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wbits: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 chk(what, exp, rdata);
	endtask : rd
	// Pins need two sync edges plus one register edge to show
	task automatic settle;
		repeat (4) @(posedge clk);
		#1;
	endtask : settle
	task automatic wait_flag(input logic exp);
		int n;
		n = 0;
		while (flag !== exp && n < 10) begin
			@(posedge clk);
			#1 n++;
		end
		chk("change flag", {7'h00, exp}, {7'h00, flag});
		// A flag that never arrives ends the run at once
		if (flag !== exp) begin
			end_sim();
		end
	endtask : wait_flag
	task automatic reg_table;
		for (int i = 0; i < 6; i++) begin
			rd(rst_addr[i], rst_val[i], "register reset");
		end
	endtask : reg_table
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_sim

	// A hang counts as a mismatch
	initial begin
		#100000;
		fails++;
		end_sim();
	end
	// ============================================================
	// Main sequence
	initial begin
		rstn = 1'b0;
		other_rst = 1'b0;
		bus = '0;
		pa_ext = 5'h00;
		pb_ext = 8'h00;
		pb_ext_en = 8'hff;
		ext_int_en = 1'b0;
		prog_mode = 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		reg_table();
		chk("reset pull-ups", 8'h00, pb_pu);
		chk("reset analog", 8'h0f, {4'h0, pa_an});
		$display("test reset values done");
		pa_ext <= 5'h1f;
		for (int c = 0; c < 4; c++) begin
			wr(8'h9f, 8'(c), 8'h00);
			rd(8'h05, an_exp[c], "analog view");
		end
		$display("test analog select done");
		pa_ext <= 5'h15;
		settle();
		wr(8'h05, 8'h00, 8'h01);
		wr(8'h85, 8'h00, 8'h00);
		settle();
		chk("first drive", 8'h04, {3'h0, pa_out});
		chk("first enable", 8'h0f, {3'h0, pa_oe});
		chk("timer clock", 8'h01, {7'h00, tmr});
		rd(8'h05, 8'h14, "first pins");
		$display("test first port done");
		wr(8'h81, 8'h7f, 8'h00);
		wr(8'h86, 8'hf0, 8'h00);
		pb_ext_en <= 8'h00;
		settle();
		chk("pull-ups", 8'hf0, pb_pu);
		chk("second enable", 8'h0f, pb_oe);
		rd(8'h06, 8'hf0, "second pins");
		wr(8'h0b, 8'h00, 8'h00);
		wait_flag(1'b0);
		pb_ext <= 8'hef;
		pb_ext_en <= 8'hf0;
		wait_flag(1'b1);
		wr(8'h0b, 8'h00, 8'h00);
		settle();
		chk("flag kept", 8'h01, {7'h00, flag});
		chk("wake", 8'h01, {7'h00, wake});
		rd(8'h06, 8'he0, "second pins");
		wr(8'h0b, 8'h00, 8'h00);
		wait_flag(1'b0);
		wr(8'h86, 8'h00, 8'h00);
		settle();
		chk("flag excluded", 8'h00, {7'h00, flag});
		// Upper nibble zero keeps the snapshot matching once pins turn inputs
		wr(8'h06, 8'h0d, 8'hff);
		$display("test change flag done");
		prog_mode <= 1'b1;
		ext_int_en <= 1'b1;
		pb_ext <= 8'h6f;
		pb_ext_en <= 8'hff;
		settle();
		chk("prog enable", 8'h00, pb_oe & 8'hc0);
		chk("prog lines", 8'h01, {6'h00, pdat, pclk});
		chk("schmitt", 8'h01, {7'h00, schm});
		chk("second drive", 8'h0d, pb_out);
		chk("ext interrupt", 8'h01, {7'h00, eint});
		prog_mode <= 1'b0;
		pb_ext <= 8'h00;
		$display("test shared pins done");
		@(posedge clk);
		other_rst <= 1'b1;
		@(posedge clk);
		other_rst <= 1'b0;
		reg_table();
		chk("second latch kept", 8'h0d, pb_out);
		chk("first latch kept", 8'h04, {3'h0, pa_out});
		$display("test other reset done");
		end_sim();
	end
endmodule : test_gpio_dual_port
